// ---- dv/ncj_host_model.sv ----
`default_nettype none
// ============================================================
// Host processor model on the control write and read ports
module ncj_host_model
	import ncj_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Control ports toward the device
	output logic cfgWrEn,
	output logic [4:0] cfgAddr,
	output logic [7:0] cfgWrData,
	output logic [4:0] cfgRdAddr,
	input wire logic [7:0] cfgRdData
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet port at time zero
	initial begin
		cfgWrEn = 1'b0;
		cfgAddr = 5'h00;
		cfgWrData = 8'h00;
		cfgRdAddr = 5'h00;
	end

	// One write, strobe up for one edge; idle lines never echo the last write
	task automatic wr(input logic [4:0] addr, input logic [7:0] data);
		@(posedge core_clk);
		#1;
		cfgWrEn = 1'b1;
		cfgAddr = addr;
		cfgWrData = data;
		@(posedge core_clk);
		#1;
		cfgWrEn = 1'b0;
		cfgAddr = ~addr;
		cfgWrData = ~data;
	endtask

	// Trigger goes last and never with a delay below 2, the least valid value
	task automatic trigger(input logic [7:0] dly);
		wr(ADDR_JITTER_TRIGGER, (dly < 8'h02) ? 8'h02 : dly);
	endtask

	// Read data is registered, so it is taken one edge after the address
	task automatic rd(input logic [4:0] addr, output logic [7:0] data);
		@(posedge core_clk);
		#1;
		cfgRdAddr = addr;
		@(posedge core_clk);
		#1;
		data = cfgRdData;
	endtask
endmodule
`default_nettype wire

// ---- dv/ncj_jitter_top_tb.sv ----
`default_nettype none
// ============================================================
// Self-checking bench of the sample clock phase stepper
module ncj_jitter_top_tb
	import ncj_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic cfgWrEn;
	logic [4:0] cfgAddr;
	logic [7:0] cfgWrData;
	logic [4:0] cfgRdAddr;
	logic [7:0] cfgRdData;
	logic adcSampleClk;
	logic jitterActive;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	logic [7:0] perQ[$];
	logic [7:0] perCnt = 8'h00;
	logic prevClk = 1'b1;
	logic sawActive = 1'b0;

	// ============================================================
	// Design and host
	ncj_jitter_top u_ncj_jitter_top (.core_clk(core_clk), .rst(rst), .cfgWrEn(cfgWrEn),
		.cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdAddr(cfgRdAddr),
		.cfgRdData(cfgRdData), .adcSampleClk(adcSampleClk), .jitterActive(jitterActive));
	ncj_host_model u_ncj_host_model (.core_clk(core_clk), .cfgWrEn(cfgWrEn), .cfgAddr(cfgAddr),
		.cfgWrData(cfgWrData), .cfgRdAddr(cfgRdAddr), .cfgRdData(cfgRdData));

	// 200 MHz clock
	always #2.5 core_clk = ~core_clk;

	// Rise-to-rise period lengths; the flag remembers any sight of the step mode
	always @(posedge core_clk) begin
		prevClk <= adcSampleClk;
		if (jitterActive === 1'b1) sawActive <= 1'b1;
		if (adcSampleClk === 1'b1 && prevClk === 1'b0) begin
			perQ.push_back(perCnt);
			perCnt <= 8'h01;
		end else begin
			perCnt <= perCnt + 8'h01;
		end
	end

	// Hang guard: the longest event needs about 25k cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 80000) begin
			errors++;
			close_out();
		end
	end

	// ============================================================
	// Expectation and comparison
	// Index 0 is the period the trigger lands in; stepping starts dly periods later
	function automatic logic [7:0] expPer(int i, logic [6:0] def, logic [3:0] step,
		logic [3:0] rep, logic [7:0] dly);
		if (step != 4'h0 && i >= int'(dly) && i < int'(dly) + int'(rep))
			return {1'b0, def} + {{4{step[3]}}, step};
		return {1'b0, def};
	endfunction

	task automatic chkVal(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkFlag(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Wait for n whole periods, bounded so a stopped clock cannot hang
	task automatic collect(input int n);
		int guard;
		guard = 0;
		while (perQ.size() < n && guard < 30000) begin
			@(posedge core_clk);
			guard++;
		end
	endtask

	// One event: program, trigger just after a period start, then watch periods and flag
	task automatic runEvent(input logic [6:0] def, input logic [3:0] step,
		input logic [3:0] rep, input logic [7:0] dly);
		int n;
		logic [7:0] v;
		n = int'(dly) + int'(rep) + 2;
		u_ncj_host_model.wr(ADDR_DEFAULT_DIVIDE, {1'b1, def});
		u_ncj_host_model.wr(ADDR_PHASE_STEP, {step, rep});
		perQ.delete();
		collect(2);
		u_ncj_host_model.trigger(dly);
		perQ.delete();
		sawActive = 1'b0;
		collect(n);
		for (int i = 0; i < n; i++) begin
			chkVal("period", expPer(i, def, step, rep, dly), perQ[i]);
		end
		chkFlag("jitterActive", step != 4'h0 && rep != 4'h0, sawActive);
		u_ncj_host_model.rd(ADDR_PHASE_STEP, v);
		chkVal("phase step", {step, rep}, v);
		u_ncj_host_model.rd(ADDR_DEFAULT_DIVIDE, v);
		chkVal("default divide", {1'b0, def}, v);
		u_ncj_host_model.rd(ADDR_JITTER_TRIGGER, v);
		chkVal("trigger", 8'h00, v);
		// No second event without a fresh trigger, although step values stay set
		perQ.delete();
		collect(2);
		for (int i = 0; i < 2; i++) chkVal("idle period", {1'b0, def}, perQ[i]);
	endtask

	task automatic close_out();
		if (errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ============================================================
	// Main sequence: reset values, corner events, then random events
	initial begin
		logic [7:0] v;
		void'($urandom(32'h55C1));
		repeat (10) @(posedge core_clk);
		#1;
		rst = 1'b0;
		u_ncj_host_model.rd(ADDR_DEFAULT_DIVIDE, v);
		chkVal("default divide reset", 8'h40, v);
		u_ncj_host_model.rd(ADDR_PHASE_STEP, v);
		chkVal("phase step reset", 8'h00, v);
		u_ncj_host_model.rd(5'h1F, v);
		chkVal("unmapped", 8'h00, v);
		perQ.delete();
		collect(3);
		for (int i = 1; i < 3; i++) chkVal("nominal period", 8'h40, perQ[i]);
		runEvent(7'h40, 4'hF, 4'h3, 8'h02);
		runEvent(7'h40, 4'h0, 4'h5, 8'h03);
		runEvent(7'h40, 4'h1, 4'h0, 8'h03);
		runEvent(7'h3F, 4'hF, 4'h2, 8'h05);
		runEvent(7'h38, 4'h8, 4'hF, 8'h02);
		runEvent(7'h56, 4'h7, 4'h1, 8'hFF);
		// Default 56..85 keeps default plus step inside 48..92
		for (int k = 0; k < 8; k++) begin
			runEvent(7'(56 + $urandom_range(29)), 4'($urandom_range(15)),
				4'($urandom_range(15)), 8'(2 + $urandom_range(4)));
		end
		close_out();
	end
endmodule
`default_nettype wire

// ---- hw/ncj_div_if.sv ----
`default_nettype none
// ============================================================
// Link between the step sequencer and the programmable divider
interface ncj_div_if;
	logic [7:0] divisor;
	logic preWrap;
	logic sampleClk;

	modport seqSide (
		output divisor,
		input preWrap,
		input sampleClk
	);

	modport divSide (
		input divisor,
		output preWrap,
		output sampleClk
	);
endinterface
`default_nettype wire

// ---- hw/ncj_divider.sv ----
`default_nettype none
// ============================================================
// Programmable divider of the fast clock into the sample clock
module ncj_divider
	import ncj_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Sequencer side
	ncj_div_if.divSide dv
);

	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] div;
		logic clk;
	} ncj_div_state_t;

	ncj_div_state_t st_ff;
	ncj_div_state_t nxt_st;

	// One cycle of warning lets the sequencer settle the next ratio in time
	assign dv.preWrap = (st_ff.cnt == 8'(st_ff.div - 8'h02));
	assign dv.sampleClk = st_ff.clk;

	// Next ratio is taken only at a period boundary, so no period is torn
	always_comb begin
		nxt_st = st_ff;
		if (st_ff.cnt == 8'(st_ff.div - 8'h01)) begin
			nxt_st.cnt = 8'h00;
			nxt_st.div = (dv.divisor < MIN_DIVISOR) ? MIN_DIVISOR : dv.divisor;
		end else begin
			nxt_st.cnt = 8'(st_ff.cnt + 8'h01);
		end
		// High for the first div/2 cycles of each period, rounded down
		nxt_st.clk = (nxt_st.cnt < {1'b0, nxt_st.div[7:1]});
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{cnt: 8'h00, div: RST_DIVISOR, clk: 1'b1};
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule
`default_nettype wire

// ---- hw/ncj_jitter_top.sv ----
`default_nettype none
// Summary of operation
// - A jitter event starts only after a write to the trigger register.
// - The trigger register keeps no value; each event needs a fresh write.
// - Default divide, step value and repeat keep their values until rewritten or reset.
// - During the event the divide ratio is default plus signed step value.
// - Modified ratio lasts repeat-count sample periods, then normal division returns.
// - Event begins the written number of sample periods after the trigger write.
// - A zero step value makes a trigger write leave the clock unchanged.
// - A zero repeat count behaves like a zero step value.
// - Step value is 4-bit two's complement in bits 7 to 4.
// - Repeat count is 4-bit unsigned in bits 3 to 0.
// - Positive step lengthens periods, negative step shortens them.
// - Divide ratio 64 yields the nominal sample clock from the fast clock.
// - Delay field gives sample periods before jitter, 2 to 255 valid; the code also takes 1 and treats 0 as 1.
// - Default divide resets to 64, 7-bit field in bits 6 to 0.
module ncj_jitter_top
	import ncj_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register write port from the serial control deframer
	input wire logic cfgWrEn,
	input wire logic [4:0] cfgAddr,
	input wire logic [7:0] cfgWrData,
	// Register read port
	input wire logic [4:0] cfgRdAddr,
	output logic [7:0] cfgRdData,
	// Sample clock and status
	output logic adcSampleClk,
	output logic jitterActive
);

	// ============================================================
	// State
	typedef struct packed {
		logic [6:0] oscDefaultDivide;
		logic [7:0] phaseStepControl;
		ncj_mode_t mode;
		logic [7:0] delayCnt;
		logic [3:0] repeatCnt;
		logic [7:0] curDivisor;
		logic active;
		logic [7:0] rdData;
	} ncj_state_t;

	ncj_state_t st_ff;
	ncj_state_t nxt_st;

	ncj_div_if dv();

	logic trigWr;
	logic signed [3:0] oscStepValue;
	logic [3:0] oscStepRepeat;
	logic [7:0] defaultDivisor;
	logic [7:0] steppedDivisor;

	// ============================================================
	// Field decode
	assign trigWr = cfgWrEn && (cfgAddr == ADDR_JITTER_TRIGGER);
	assign oscStepValue = st_ff.phaseStepControl[STEP_VALUE_MSB:STEP_VALUE_LSB];
	assign oscStepRepeat = st_ff.phaseStepControl[STEP_REPEAT_MSB:STEP_REPEAT_LSB];
	assign defaultDivisor = {1'b0, st_ff.oscDefaultDivide};
	// Sign extension: a positive step lengthens, a negative one shortens
	assign steppedDivisor = 8'(defaultDivisor + {{4{oscStepValue[3]}}, oscStepValue});

	assign dv.divisor = st_ff.curDivisor;
	assign cfgRdData = st_ff.rdData;
	assign adcSampleClk = dv.sampleClk;
	assign jitterActive = st_ff.active;

	// ============================================================
	// Register file and step sequencer
	always_comb begin
		nxt_st = st_ff;
		// Settings change only by host writes; events never touch them
		if (cfgWrEn && cfgAddr == ADDR_DEFAULT_DIVIDE) begin
			nxt_st.oscDefaultDivide = cfgWrData[DEFAULT_DIVIDE_MSB:0];
		end
		if (cfgWrEn && cfgAddr == ADDR_PHASE_STEP) begin
			nxt_st.phaseStepControl = cfgWrData;
		end
		// Sequencer advances one step per sample period boundary
		if (dv.preWrap) begin
			case (st_ff.mode)
				MODE_IDLE: begin
					nxt_st.curDivisor = defaultDivisor;
				end
				MODE_WAIT: begin
					if (st_ff.delayCnt > MIN_JITTER_DELAY) begin
						nxt_st.delayCnt = 8'(st_ff.delayCnt - 8'h01);
						nxt_st.curDivisor = defaultDivisor;
					end else if (oscStepValue == 4'h0 || oscStepRepeat == 4'h0) begin
						// Nothing to apply: quietly back to idle
						nxt_st.mode = MODE_IDLE;
						nxt_st.curDivisor = defaultDivisor;
					end else begin
						nxt_st.mode = MODE_STEP;
						nxt_st.repeatCnt = oscStepRepeat;
						nxt_st.curDivisor = steppedDivisor;
					end
				end
				MODE_STEP: begin
					if (st_ff.repeatCnt == 4'h1) begin
						nxt_st.mode = MODE_IDLE;
						nxt_st.curDivisor = defaultDivisor;
					end else begin
						nxt_st.repeatCnt = 4'(st_ff.repeatCnt - 4'h1);
						nxt_st.curDivisor = steppedDivisor;
					end
				end
				default: begin
					nxt_st.mode = MODE_IDLE;
					nxt_st.curDivisor = defaultDivisor;
				end
			endcase
		end
		// A trigger write rearms even mid-event; it wins over the boundary step
		if (trigWr) begin
			nxt_st.mode = MODE_WAIT;
			// An aborted event must not leave a stepped ratio queued behind the new wait
			nxt_st.curDivisor = defaultDivisor;
			// Invalid 0 gets the same schedule as 1 rather than wrapping to 256
			nxt_st.delayCnt = (cfgWrData < MIN_JITTER_DELAY) ? MIN_JITTER_DELAY
				: cfgWrData;
		end
		nxt_st.active = (nxt_st.mode == MODE_STEP);
		// Registered read; the trigger register reads back zero
		case (cfgRdAddr)
			ADDR_DEFAULT_DIVIDE: nxt_st.rdData = defaultDivisor;
			ADDR_PHASE_STEP: nxt_st.rdData = st_ff.phaseStepControl;
			ADDR_JITTER_TRIGGER: nxt_st.rdData = 8'h00;
			default: nxt_st.rdData = 8'h00;
		endcase
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{oscDefaultDivide: RST_DEFAULT_DIVIDE,
				phaseStepControl: RST_PHASE_STEP,
				mode: MODE_IDLE,
				delayCnt: 8'h00,
				repeatCnt: 4'h0,
				curDivisor: RST_DIVISOR,
				active: 1'b0,
				rdData: 8'h00};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ============================================================
	// Divider
	ncj_divider u_divider (
		.core_clk(core_clk),
		.rst(rst),
		.dv(dv.divSide)
	);

	// ============================================================
	// Assertions
	property p_noStepWithoutArm;
		@(posedge core_clk) disable iff (rst)
		(st_ff.mode == MODE_IDLE && !trigWr) |=> (st_ff.mode != MODE_STEP);
	endproperty
	a_noStepWithoutArm: assert property (p_noStepWithoutArm)
		else $error("step entered without a trigger write");

	property p_triggerReadsZero;
		@(posedge core_clk) disable iff (rst)
		(cfgRdAddr == ADDR_JITTER_TRIGGER) |=> (cfgRdData == 8'h00);
	endproperty
	a_triggerReadsZero: assert property (p_triggerReadsZero)
		else $error("trigger register read back nonzero");

	property p_settingsHeld;
		@(posedge core_clk) disable iff (rst)
		!(cfgWrEn && cfgAddr == ADDR_PHASE_STEP) |=> $stable(st_ff.phaseStepControl);
	endproperty
	a_settingsHeld: assert property (p_settingsHeld)
		else $error("phase step control changed without a write");

	property p_stepRatio;
		@(posedge core_clk) disable iff (rst)
		(dv.preWrap && st_ff.mode == MODE_STEP && st_ff.repeatCnt != 4'h1 && !trigWr)
		|=> (st_ff.curDivisor == $past(steppedDivisor)) && st_ff.active;
	endproperty
	a_stepRatio: assert property (p_stepRatio)
		else $error("stepped divisor not default plus step");

	property p_stepEnds;
		@(posedge core_clk) disable iff (rst)
		(dv.preWrap && st_ff.mode == MODE_STEP && st_ff.repeatCnt == 4'h1 && !trigWr)
		|=> (st_ff.mode == MODE_IDLE) && (st_ff.curDivisor == $past(defaultDivisor));
	endproperty
	a_stepEnds: assert property (p_stepEnds)
		else $error("event did not return to default divisor");

	property p_delayCount;
		@(posedge core_clk) disable iff (rst)
		(dv.preWrap && st_ff.mode == MODE_WAIT && st_ff.delayCnt > 8'h01 && !trigWr)
		|=> (st_ff.mode == MODE_WAIT) && (st_ff.delayCnt == $past(st_ff.delayCnt) - 1);
	endproperty
	a_delayCount: assert property (p_delayCount)
		else $error("delay count did not step by one period");

	property p_nullEvent;
		@(posedge core_clk) disable iff (rst)
		(dv.preWrap && st_ff.mode == MODE_WAIT && st_ff.delayCnt <= 8'h01 && !trigWr
			&& (oscStepValue == 4'h0 || oscStepRepeat == 4'h0))
		|=> (st_ff.mode == MODE_IDLE) && (st_ff.curDivisor == $past(defaultDivisor));
	endproperty
	a_nullEvent: assert property (p_nullEvent)
		else $error("zero step or repeat altered the clock");

	property p_armLoad;
		@(posedge core_clk) disable iff (rst)
		trigWr |=> (st_ff.mode == MODE_WAIT)
			&& (st_ff.delayCnt == (($past(cfgWrData) < 8'h01) ? 8'h01 : $past(cfgWrData)));
	endproperty
	a_armLoad: assert property (p_armLoad)
		else $error("trigger write did not load delay");

	property p_activeOnlyInStep;
		@(posedge core_clk) disable iff (rst)
		jitterActive |-> (st_ff.mode == MODE_STEP)
			&& (!$rose(jitterActive) || ($past(dv.preWrap) && $past(st_ff.mode) == MODE_WAIT));
	endproperty
	a_activeOnlyInStep: assert property (p_activeOnlyInStep)
		else $error("active flag outside an event");

	// Main scenarios
	c_enterStep: cover property (@(posedge core_clk) disable iff (rst)
		st_ff.mode == MODE_WAIT ##1 st_ff.mode == MODE_STEP);
	c_leaveStep: cover property (@(posedge core_clk) disable iff (rst)
		st_ff.mode == MODE_STEP ##1 st_ff.mode == MODE_IDLE);
	c_nullEvent: cover property (@(posedge core_clk) disable iff (rst)
		st_ff.mode == MODE_WAIT && oscStepValue == 4'h0 ##1 st_ff.mode == MODE_IDLE);
	c_rearmInStep: cover property (@(posedge core_clk) disable iff (rst)
		st_ff.mode == MODE_STEP && trigWr);

endmodule
`default_nettype wire

// ---- hw/ncj_pkg.sv ----
`default_nettype none
// ============================================================
// Shared constants of the sample clock phase stepper
package ncj_pkg;

	// ============================================================
	// Register addresses on the control write port
	localparam logic [4:0] ADDR_DEFAULT_DIVIDE = 5'h0C;
	localparam logic [4:0] ADDR_JITTER_TRIGGER = 5'h0D;
	localparam logic [4:0] ADDR_PHASE_STEP = 5'h0E;

	// ============================================================
	// Field positions of the phase step control and default divide registers
	localparam int STEP_VALUE_MSB = 7;
	localparam int STEP_VALUE_LSB = 4;
	localparam int STEP_REPEAT_MSB = 3;
	localparam int STEP_REPEAT_LSB = 0;
	localparam int DEFAULT_DIVIDE_MSB = 6;

	// ============================================================
	// Values after reset
	localparam logic [6:0] RST_DEFAULT_DIVIDE = 7'h40;
	localparam logic [7:0] RST_PHASE_STEP = 8'h00;
	localparam logic [7:0] RST_DIVISOR = 8'h40;

	// ============================================================
	// Counts
	localparam logic [7:0] MIN_JITTER_DELAY = 8'h01;
	localparam logic [7:0] MIN_DIVISOR = 8'h04;

	// Nominal clock plan: master input times the multiplier, divided by 64
	localparam real MASTER_CLK_MHZ = 35.328;
	localparam int PLL_MULTIPLIER = 4;
	localparam real NOMINAL_SAMPLE_MHZ = 2.208;

	// ============================================================
	// Sequencer modes
	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_WAIT = 2'b01,
		MODE_STEP = 2'b10
	} ncj_mode_t;

endpackage
`default_nettype wire
